// ---- pod_pkg.sv ----
// constants and types for the peak and overlevel detector
package pod_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int POD_DW = 24;
    localparam int POD_PH = 3;
    localparam int POD_AW = 8;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [POD_AW-1:0] POD_A_STATUS = 8'h00;
    localparam logic [POD_AW-1:0] POD_A_ENABLE = 8'h04;
    localparam logic [POD_AW-1:0] POD_A_PHASE = 8'h08;
    localparam logic [POD_AW-1:0] POD_A_MODE = 8'h0C;
    localparam logic [POD_AW-1:0] POD_A_PCYC = 8'h10;
    localparam logic [POD_AW-1:0] POD_A_VTHR = 8'h14;
    localparam logic [POD_AW-1:0] POD_A_ITHR = 8'h18;
    localparam logic [POD_AW-1:0] POD_A_VOLTAGE_PEAK_RESULT = 8'h1C;
    localparam logic [POD_AW-1:0] POD_A_CURRENT_PEAK_RESULT = 8'h20;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POD_ST_OI = 17;
    localparam int POD_ST_OV = 18;
    localparam int POD_ST_PKI = 23;
    localparam int POD_ST_PKV = 24;
    localparam int POD_PH_OI_LO = 3;
    localparam int POD_PH_OV_LO = 9;
    localparam int POD_SEL_LO = 2;
    localparam int POD_RES_W = POD_DW + POD_PH;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [POD_DW-1:0] POD_FULL_SCALE = 24'h5A7540;
    localparam logic [31:0] POD_ZERO = 32'h00000000;
    // ------------------------------------------------------------
    // sample stream from the metering datapath
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [POD_PH-1:0] zero_cross;
        logic [POD_PH-1:0][POD_DW-1:0] volt;
        logic [POD_PH-1:0][POD_DW-1:0] curr;
    } pod_samples_t;
endpackage : pod_pkg

// ---- pod_detector.sv ----
// peak and overlevel detector with apb register slave
// Functional notes
// - track voltage and current peaks, low 24 bits
// - period length is programmed half cycle count
// - mode bits 4:2 select phases A, B, C
// - every selected phase's crossing advances count
// - new peak sets one phase tag bit 26:24
// - tag is one-hot, or zero when no selected sample was nonzero, bit 24 A, 25 B
// - result and tag change only at period end
// - current period end sets status 23, masked irq
// - voltage period end sets status 24, masked irq
// - write one clears status bit, line releases
// - count write with phases selected restarts counter
// - compare sample magnitudes against 24-bit unsigned thresholds
// - overvoltage sets bit 18 and phase bits 11:9
// - phase A overvoltage sets phase bit 9
// - clearing bit 18 clears phase bits 11:9
// - overcurrent sets bit 17 and phase bits 5:3
// - clearing bit 17 clears phase bits 5:3
// - zero threshold trips on any nonzero sample, full scale only on a larger one
`timescale 1ns/1ps
`default_nettype none
module pod_detector #(
    parameter int PCYC_W = 8
) (
    input wire logic pclk, // apb clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [pod_pkg::POD_AW-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire pod_pkg::pod_samples_t samples, // per-phase samples
    output logic event_line_n // event line, active low
);
    import pod_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0] event_status_reg, next_event_status_reg;
    logic [31:0] event_enable_reg, next_event_enable_reg;
    logic [31:0] phase_event_reg, next_phase_event_reg;
    logic [POD_PH-1:0] peak_phase_select, next_peak_phase_select;
    logic [PCYC_W-1:0] peak_half_cycle_count, next_peak_half_cycle_count;
    logic [POD_DW-1:0] high_voltage_threshold, next_high_voltage_threshold;
    logic [POD_DW-1:0] high_current_threshold, next_high_current_threshold;
    logic [POD_RES_W-1:0] voltage_peak_result, next_voltage_peak_result;
    logic [POD_RES_W-1:0] current_peak_result, next_current_peak_result;
    logic [PCYC_W-1:0] half_cnt, next_half_cnt;
    logic [POD_DW-1:0] v_run, next_v_run, i_run, next_i_run;
    logic [POD_PH-1:0] v_run_ph, next_v_run_ph, i_run_ph, next_i_run_ph;
    logic [31:0] next_prdata;
    logic next_pslverr;

    // ------------------------------------------------------------
    // combinational helpers
    // ------------------------------------------------------------
    logic setup, wr_en, mapped;
    logic [31:0] rd_val;
    logic [POD_PH-1:0][POD_DW-1:0] v_abs, i_abs;
    logic [POD_PH-1:0] ov_ph, oi_ph, zx_sel;
    logic [1:0] zx_n;
    logic [PCYC_W:0] cnt_sum;
    logic period_end;
    logic [POD_DW-1:0] v_best, i_best;
    logic [POD_PH-1:0] v_best_ph, i_best_ph;
    logic [31:0] st_set, st_clr, ph_set, ph_clr;

    function automatic logic [POD_DW-1:0] pod_abs(input logic [POD_DW-1:0] x);
        return x[POD_DW-1] ? POD_DW'(-x) : x;
    endfunction : pod_abs

    assign pready = 1'b1;

    // ------------------------------------------------------------
    // apb decode and read mux
    // ------------------------------------------------------------
    always_comb begin
        setup = psel & ~penable;
        wr_en = psel & penable & pwrite;
        mapped = 1'b1;
        rd_val = POD_ZERO;
        if (paddr == POD_A_STATUS) begin
            rd_val = event_status_reg;
        end else if (paddr == POD_A_ENABLE) begin
            rd_val = event_enable_reg;
        end else if (paddr == POD_A_PHASE) begin
            rd_val = phase_event_reg;
        end else if (paddr == POD_A_MODE) begin
            rd_val = 32'(peak_phase_select) << POD_SEL_LO;
        end else if (paddr == POD_A_PCYC) begin
            rd_val = 32'(peak_half_cycle_count);
        end else if (paddr == POD_A_VTHR) begin
            rd_val = 32'(high_voltage_threshold);
        end else if (paddr == POD_A_ITHR) begin
            rd_val = 32'(high_current_threshold);
        end else if (paddr == POD_A_VOLTAGE_PEAK_RESULT) begin
            rd_val = 32'(voltage_peak_result);
        end else if (paddr == POD_A_CURRENT_PEAK_RESULT) begin
            rd_val = 32'(current_peak_result);
        end else begin
            mapped = 1'b0;
        end
        // read data is captured in setup so it comes from a flop with zero wait states
        next_prdata = setup ? rd_val : prdata;
        next_pslverr = setup ? ~mapped : (psel & pslverr);
    end

    // ------------------------------------------------------------
    // peak tracking and overlevel detection
    // ------------------------------------------------------------
    always_comb begin
        zx_sel = samples.zero_cross & peak_phase_select;
        zx_n = 2'h0;
        v_best = v_run;
        i_best = i_run;
        v_best_ph = v_run_ph;
        i_best_ph = i_run_ph;
        for (int p = 0; p < POD_PH; p++) begin
            v_abs[p] = pod_abs(samples.volt[p]);
            i_abs[p] = pod_abs(samples.curr[p]);
            zx_n = zx_n + 2'(zx_sel[p]);
            ov_ph[p] = samples.valid & (v_abs[p] > high_voltage_threshold);
            oi_ph[p] = samples.valid & (i_abs[p] > high_current_threshold);
            // later phase wins only when strictly larger, so the tag stays one-hot
            if (samples.valid && peak_phase_select[p] && v_abs[p] > v_best) begin
                v_best = v_abs[p];
                v_best_ph = POD_PH'(1) << p;
            end
            if (samples.valid && peak_phase_select[p] && i_abs[p] > i_best) begin
                i_best = i_abs[p];
                i_best_ph = POD_PH'(1) << p;
            end
        end
        cnt_sum = {1'b0, half_cnt} + (PCYC_W+1)'(zx_n);
        // a zero count never ends a period
        period_end = (zx_n != 2'h0) && (peak_half_cycle_count != '0)
            && (cnt_sum >= {1'b0, peak_half_cycle_count});
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_event_enable_reg = event_enable_reg;
        next_peak_phase_select = peak_phase_select;
        next_peak_half_cycle_count = peak_half_cycle_count;
        next_high_voltage_threshold = high_voltage_threshold;
        next_high_current_threshold = high_current_threshold;
        next_voltage_peak_result = voltage_peak_result;
        next_current_peak_result = current_peak_result;
        st_set = POD_ZERO;
        st_clr = POD_ZERO;
        ph_set = POD_ZERO;
        ph_clr = POD_ZERO;
        if (period_end) begin
            next_half_cnt = '0;
            next_v_run = '0;
            next_i_run = '0;
            next_v_run_ph = '0;
            next_i_run_ph = '0;
            next_voltage_peak_result = {v_best_ph, v_best};
            next_current_peak_result = {i_best_ph, i_best};
            st_set[POD_ST_PKI] = 1'b1;
            st_set[POD_ST_PKV] = 1'b1;
        end else begin
            next_half_cnt = cnt_sum[PCYC_W-1:0];
            next_v_run = v_best;
            next_i_run = i_best;
            next_v_run_ph = v_best_ph;
            next_i_run_ph = i_best_ph;
        end
        st_set[POD_ST_OV] = |ov_ph;
        st_set[POD_ST_OI] = |oi_ph;
        ph_set[POD_PH_OV_LO +: POD_PH] = ov_ph;
        ph_set[POD_PH_OI_LO +: POD_PH] = oi_ph;
        if (wr_en) begin
            if (paddr == POD_A_STATUS) begin
                st_clr = pwdata;
                if (pwdata[POD_ST_OV]) begin
                    ph_clr[POD_PH_OV_LO +: POD_PH] = '1;
                end
                if (pwdata[POD_ST_OI]) begin
                    ph_clr[POD_PH_OI_LO +: POD_PH] = '1;
                end
            end else if (paddr == POD_A_ENABLE) begin
                next_event_enable_reg = pwdata;
            end else if (paddr == POD_A_MODE) begin
                next_peak_phase_select = pwdata[POD_SEL_LO +: POD_PH];
            end else if (paddr == POD_A_PCYC) begin
                next_peak_half_cycle_count = pwdata[PCYC_W-1:0];
                if (peak_phase_select != '0) begin
                    next_half_cnt = '0;
                    next_v_run = '0;
                    next_i_run = '0;
                    next_v_run_ph = '0;
                    next_i_run_ph = '0;
                end
            end else if (paddr == POD_A_VTHR) begin
                next_high_voltage_threshold = pwdata[POD_DW-1:0];
            end else if (paddr == POD_A_ITHR) begin
                next_high_current_threshold = pwdata[POD_DW-1:0];
            end
        end
        // a fresh event in the clearing cycle survives the clear
        next_event_status_reg = (event_status_reg & ~st_clr) | st_set;
        next_phase_event_reg = (phase_event_reg & ~ph_clr) | ph_set;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_status_reg <= POD_ZERO;
            event_enable_reg <= POD_ZERO;
            phase_event_reg <= POD_ZERO;
            peak_phase_select <= '0;
            peak_half_cycle_count <= '0;
            high_voltage_threshold <= POD_FULL_SCALE;
            high_current_threshold <= POD_FULL_SCALE;
            voltage_peak_result <= '0;
            current_peak_result <= '0;
            half_cnt <= '0;
            v_run <= '0;
            i_run <= '0;
            v_run_ph <= '0;
            i_run_ph <= '0;
            prdata <= POD_ZERO;
            pslverr <= 1'b0;
        end else begin
            event_status_reg <= next_event_status_reg;
            event_enable_reg <= next_event_enable_reg;
            phase_event_reg <= next_phase_event_reg;
            peak_phase_select <= next_peak_phase_select;
            peak_half_cycle_count <= next_peak_half_cycle_count;
            high_voltage_threshold <= next_high_voltage_threshold;
            high_current_threshold <= next_high_current_threshold;
            voltage_peak_result <= next_voltage_peak_result;
            current_peak_result <= next_current_peak_result;
            half_cnt <= next_half_cnt;
            v_run <= next_v_run;
            i_run <= next_i_run;
            v_run_ph <= next_v_run_ph;
            i_run_ph <= next_i_run_ph;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    assign event_line_n = ~|(event_status_reg & event_enable_reg);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_voltage_peak_result_load;
        period_end |=> voltage_peak_result == {$past(v_best_ph), $past(v_best)};
    endproperty
    a_voltage_peak_result_load: assert property (p_voltage_peak_result_load) else $error("voltage peak not loaded");

    property p_hold;
        !period_end |=> $stable(current_peak_result) && $stable(voltage_peak_result);
    endproperty
    a_hold: assert property (p_hold) else $error("peak changed mid period");

    property p_onehot;
        $onehot0(current_peak_result[POD_RES_W-1:POD_DW]) && $onehot0(voltage_peak_result[POD_RES_W-1:POD_DW]);
    endproperty
    a_onehot: assert property (p_onehot) else $error("phase tag not one-hot");

    property p_pk_flags;
        period_end |=> event_status_reg[POD_ST_PKI] && event_status_reg[POD_ST_PKV];
    endproperty
    a_pk_flags: assert property (p_pk_flags) else $error("peak done flags not set");

    property p_line_low;
        event_status_reg[POD_ST_PKV] && event_enable_reg[POD_ST_PKV] |-> !event_line_n;
    endproperty
    a_line_low: assert property (p_line_low) else $error("line not low on peak");

    property p_w1c;
        wr_en && paddr == POD_A_STATUS && pwdata[POD_ST_PKV] && !period_end
            |=> !event_status_reg[POD_ST_PKV];
    endproperty
    a_w1c: assert property (p_w1c) else $error("status bit not cleared");

    property p_ov_a;
        samples.valid && v_abs[0] > high_voltage_threshold
            |=> event_status_reg[POD_ST_OV] && phase_event_reg[POD_PH_OV_LO];
    endproperty
    a_ov_a: assert property (p_ov_a) else $error("phase A overvoltage missed");

    property p_ov_clr;
        wr_en && paddr == POD_A_STATUS && pwdata[POD_ST_OV] && ov_ph == '0
            |=> phase_event_reg[POD_PH_OV_LO +: POD_PH] == '0 && !event_status_reg[POD_ST_OV];
    endproperty
    a_ov_clr: assert property (p_ov_clr) else $error("overvoltage bits not cleared");

    property p_oi_clr;
        wr_en && paddr == POD_A_STATUS && pwdata[POD_ST_OI] && oi_ph == '0
            |=> phase_event_reg[POD_PH_OI_LO +: POD_PH] == '0 && !event_status_reg[POD_ST_OI];
    endproperty
    a_oi_clr: assert property (p_oi_clr) else $error("overcurrent bits not cleared");

    property p_oi_set;
        |oi_ph |=> event_status_reg[POD_ST_OI] && (phase_event_reg[POD_PH_OI_LO +: POD_PH] & $past(oi_ph)) != '0;
    endproperty
    a_oi_set: assert property (p_oi_set) else $error("overcurrent not flagged");

    property p_restart;
        wr_en && paddr == POD_A_PCYC && peak_phase_select != '0 |=> half_cnt == '0;
    endproperty
    a_restart: assert property (p_restart) else $error("counter not restarted");
endmodule : pod_detector
`default_nettype wire

// ---- pod_host_model.sv ----
// apb host model standing in for the metering microcontroller
`timescale 1ns/1ps
`default_nettype none
module pod_host_model (
    input wire logic pclk, // bus clock
    input wire logic presetn, // reset, active low
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // slave ready
    input wire logic pslverr, // slave error
    output logic psel, // select
    output logic penable, // access phase
    output logic pwrite, // direction
    output logic [pod_pkg::POD_AW-1:0] paddr, // byte address
    output logic [31:0] pwdata // write data
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
    end
    // ------------------------------------------------------------
    // one transfer; an idle cycle always follows so strobes never toggle twice in a step
    // ------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [pod_pkg::POD_AW-1:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err, output logic ok);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        ok = (pready === 1'b1) && (presetn === 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released bus shows inverted values so nothing relies on a stale copy
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : pod_host_model
`default_nettype wire

// ---- tb_pod_detector.sv ----
// self-checking testbench for the peak and overlevel detector
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin failures++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module tb_pod_detector;
    import pod_pkg::*;
    logic pclk;
    logic presetn;
    logic psel, penable, pwrite, pready, pslverr, event_line_n;
    logic [POD_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, d, st;
    logic last_err;
    pod_samples_t samples;
    int failures = 0;
    int tests_run = 0;
    pod_detector #(.PCYC_W(8)) pod_detector_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .samples(samples), .event_line_n(event_line_n));
    pod_host_model pod_host_model_inst (.pclk(pclk), .presetn(presetn), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic bus(input logic w, input logic [POD_AW-1:0] a, input logic [31:0] wd);
        logic ok;
        pod_host_model_inst.xfer(w, a, wd, d, last_err, ok);
        if (ok !== 1'b1) begin
            failures++;
            finish_test();
        end
    endtask : bus
    task automatic chk(input string nm, input logic [POD_AW-1:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        `CHECK(nm, exp, d)
    endtask : chk
    task automatic put(input int ch, input int p, input logic [POD_DW-1:0] v);
        logic [POD_PH-1:0][POD_DW-1:0] z;
        z = '0;
        z[p] = v;
        samples.volt <= (ch == 1) ? '0 : z;
        samples.curr <= (ch == 1) ? z : '0;
    endtask : put
    // one valid sample cycle, then one quiet cycle
    task automatic pulse(input logic [POD_PH-1:0] zc);
        samples.valid <= 1'b1;
        samples.zero_cross <= zc;
        @(posedge pclk);
        samples.valid <= 1'b0;
        samples.zero_cross <= 3'h0;
        @(posedge pclk);
    endtask : pulse
    initial begin
        repeat (30000) @(posedge pclk);
        failures++;
        finish_test();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        samples = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHECK("line_reset", 1'b1, event_line_n)
        chk("vthr_reset", POD_A_VTHR, 32'h005A7540);
        `CHECK("mapped_no_err", 1'b0, last_err)
        chk("ithr_reset", POD_A_ITHR, 32'h005A7540);
        chk("status_reset", POD_A_STATUS, 32'h00000000);
        bus(1'b1, POD_A_CURRENT_PEAK_RESULT, 32'hFFFFFFFF);
        chk("current_peak_result_ro", POD_A_CURRENT_PEAK_RESULT, 32'h00000000);
        chk("unmapped", 8'h40, 32'h00000000);
        `CHECK("unmapped_err", 1'b1, last_err)
        bus(1'b1, POD_A_ENABLE, 32'h01860000);
        for (int ch = 0; ch < 2; ch++) begin
            for (int p = 0; p < 3; p++) begin
                bus(1'b1, (ch == 1) ? POD_A_ITHR : POD_A_VTHR, 32'h00000064);
                put(ch, p, 24'h000064);
                pulse(3'h0);
                chk("equal_no_trip", POD_A_STATUS, 32'h00000000);
                put(ch, p, (p == 1) ? 24'hFFFF9B : 24'h000065);
                pulse(3'h0);
                `CHECK("line_event", 1'b0, event_line_n)
                st = (ch == 1) ? 32'h00020000 : 32'h00040000;
                chk("status_event", POD_A_STATUS, st);
                chk("phase_event", POD_A_PHASE, 32'h1 << ((ch == 1) ? 3 + p : 9 + p));
                bus(1'b1, POD_A_STATUS, st);
                chk("status_clear", POD_A_STATUS, 32'h00000000);
                chk("phase_clear", POD_A_PHASE, 32'h00000000);
                `CHECK("line_release", 1'b1, event_line_n)
                bus(1'b1, (ch == 1) ? POD_A_ITHR : POD_A_VTHR, 32'h005A7540);
            end
        end
        put(1, 0, 24'h5A7540);
        pulse(3'h0);
        chk("full_scale_never", POD_A_STATUS, 32'h00000000);
        bus(1'b1, POD_A_ITHR, 32'h00000000);
        put(1, 2, 24'h000001);
        pulse(3'h0);
        chk("zero_thr_trips", POD_A_STATUS, 32'h00020000);
        bus(1'b1, POD_A_ENABLE, 32'h00000000);
        // the write lands on the edge the task returns at, so look one edge later
        @(posedge pclk);
        `CHECK("line_masked", 1'b1, event_line_n)
        bus(1'b1, POD_A_ITHR, 32'h005A7540);
        bus(1'b1, POD_A_STATUS, 32'h00020000);
        bus(1'b1, POD_A_ENABLE, 32'h01860000);
        // peak period: phases A and B selected, four half cycles
        samples.volt <= {24'd200, 24'd30, 24'd70};
        samples.curr <= {24'd300, 24'hFFFFB0, 24'd50};
        bus(1'b1, POD_A_MODE, 32'h0000000C);
        bus(1'b1, POD_A_PCYC, 32'h00000004);
        pulse(3'b011);
        bus(1'b1, POD_A_PCYC, 32'h00000004);
        pulse(3'b011);
        pulse(3'b100);
        chk("restart_no_end", POD_A_STATUS, 32'h00000000);
        pulse(3'b001);
        chk("current_peak_result_held", POD_A_CURRENT_PEAK_RESULT, 32'h00000000);
        pulse(3'b010);
        `CHECK("line_peak", 1'b0, event_line_n)
        chk("status_peak", POD_A_STATUS, 32'h01800000);
        chk("current_peak_result_b", POD_A_CURRENT_PEAK_RESULT, 32'h02000050);
        chk("voltage_peak_result_a", POD_A_VOLTAGE_PEAK_RESULT, 32'h01000046);
        bus(1'b1, POD_A_STATUS, 32'h01800000);
        @(posedge pclk);
        `CHECK("line_peak_clear", 1'b1, event_line_n)
        samples.volt <= {24'd1, 24'd112, 24'd1};
        samples.curr <= {24'd1, 24'd10, 24'd90};
        pulse(3'b011);
        chk("current_peak_result_stable", POD_A_CURRENT_PEAK_RESULT, 32'h02000050);
        pulse(3'b011);
        chk("current_peak_result_a", POD_A_CURRENT_PEAK_RESULT, 32'h0100005A);
        chk("voltage_peak_result_b", POD_A_VOLTAGE_PEAK_RESULT, 32'h02000070);
        finish_test();
    end
endmodule : tb_pod_detector
`undef CHECK
`default_nettype wire
